// >>> common/sram_host_pkg.sv
`default_nettype none
package sram_host_pkg;
  // ==========================================================
  // Geometry of the memory
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam int WORDS  = 65536;

  // ==========================================================
  // Timing of the slowest grade, in ns, and in clock cycles
  localparam int CLK_PERIOD_NS  = 4;
  localparam int T_RC_NS        = 45;  // Read cycle time
  localparam int T_AA_NS        = 45;  // Address to data valid
  localparam int T_SA_NS        = 0;   // Address set-up to write start
  localparam int T_PWE_NS       = 22;  // Write strobe pulse width
  localparam int T_AW_NS        = 35;  // Address set-up to write end
  localparam int T_HA_NS        = 0;   // Address hold from write end
  localparam int T_HD_NS        = 0;   // Data hold from write end
  localparam int T_WC_NS        = 45;  // Write cycle time
  localparam int T_W2F_NS       = 20;  // write_to_float_delay
  localparam int T_WSETUP_NS    = 15;  // write_data_setup_time
  localparam int T_HZCE_NS      = 15;  // Deselect to high impedance

  localparam int CNT_W = 5;
  // Least times round up to whole cycles, never below one
  function automatic logic [CNT_W-1:0] cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
      c = 1;
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] RD_CYC  = cyc(T_AA_NS + CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SA_CYC  = cyc(T_SA_NS);
  localparam logic [CNT_W-1:0] WE_CYC  =
    cyc((T_AW_NS > T_W2F_NS + T_WSETUP_NS) ? T_AW_NS
        : T_W2F_NS + T_WSETUP_NS);
  localparam logic [CNT_W-1:0] HLD_CYC = cyc(T_HA_NS + T_HD_NS);
  localparam logic [CNT_W-1:0] GAP_CYC = cyc(T_HZCE_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_READ   = 3'b001,
    ST_WSETUP = 3'b010,
    ST_WPULSE = 3'b011,
    ST_WHOLD  = 3'b100,
    ST_GAP    = 3'b101
  } state_t;
endpackage
`default_nettype wire

// >>> hw/cycle_timer.sv
`default_nettype none
module cycle_timer
  import sram_host_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Control
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  // Status
  output logic                  o_done
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ==========================================================
  // Down counter, done on the last cycle of a phase
  assign o_done = (cnt_q <= CNT_ONE);
  assign cnt_d  = i_load ? i_count
                : (o_done ? CNT_ZERO : cnt_q - CNT_ONE);

  // Count register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// >>> hw/sram_host_ctrl.sv
// How it works
// - Outside reset, data and address stay steady from set-up until after the write strobe, which ends the write, has risen.
// - In a read the write strobe stays high throughout.
// - For a read the address is set before or with the falling chip selects.
// - A strobe-controlled write with output gate low lasts at least the float delay plus the data set-up.
`default_nettype none
module sram_host_ctrl
  import sram_host_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // User request
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  output logic                   o_req_ready,
  // User read answer
  output logic                   o_rsp_valid,
  output logic [DATA_W-1:0]      o_rsp_rdata,
  // Memory pins
  output logic [ADDR_W-1:0]      o_addr_pins,
  output logic                   o_first_chip_select_n,
  output logic                   o_second_chip_select_n,
  output logic                   o_write_strobe_n,
  output logic                   o_output_gate_n,
  input  wire logic [DATA_W-1:0] i_data_pins,
  output logic [DATA_W-1:0]      o_data_pins,
  output logic                   o_data_pins_oe
);
  state_t            state_q;
  state_t            state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              sel_q;
  logic              we_q;
  logic              gate_q;
  logic              drive_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rsp_q;
  logic              t_done;
  logic              t_load;
  logic [CNT_W-1:0]  t_count;
  logic              take;
  logic              sel_d;
  logic              we_d;
  logic              gate_d;
  logic              drive_d;
  logic              nxt_read;
  logic              nxt_wsetup;
  logic              nxt_wpulse;
  logic              nxt_whold;
  logic              nxt_write;
  logic              read_end;

  // ==========================================================
  // Phase timer
  cycle_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (t_load),
    .i_count (t_count),
    .o_done  (t_done)
  );

  // ==========================================================
  // Request acceptance
  assign o_req_ready = (state_q == ST_IDLE);
  assign take        = o_req_ready && i_req_valid;
  // Last cycle of a read, when the data pins have settled
  assign read_end    = (state_q == ST_READ) && t_done;

  // Next state and timer load
  // A phase of N cycles loads N; the timer flags its last cycle
  always_comb
  begin
    state_d = state_q;
    t_load  = 1'b0;
    t_count = CNT_ZERO;
    case (state_q)
      ST_IDLE:
        if (take)
        begin
          t_load  = 1'b1;
          state_d = i_req_write ? ST_WSETUP : ST_READ;
          t_count = i_req_write ? SA_CYC : RD_CYC;
        end
      ST_READ:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = GAP_CYC;
          state_d = ST_GAP;
        end
      ST_WSETUP:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = WE_CYC;
          state_d = ST_WPULSE;
        end
      ST_WPULSE:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = HLD_CYC;
          state_d = ST_WHOLD;
        end
      ST_WHOLD:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = GAP_CYC;
          state_d = ST_GAP;
        end
      ST_GAP:
        if (t_done)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Decode of the coming state
  assign nxt_read   = (state_d == ST_READ);
  assign nxt_wsetup = (state_d == ST_WSETUP);
  assign nxt_wpulse = (state_d == ST_WPULSE);
  assign nxt_whold  = (state_d == ST_WHOLD);
  assign nxt_write  = nxt_wsetup || nxt_wpulse || nxt_whold;

  // Pin levels per state, registered so the pins never glitch
  assign sel_d   = nxt_read || nxt_write;
  assign we_d    = nxt_wpulse;
  assign gate_d  = nxt_read;
  assign drive_d = nxt_write;

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Pin registers; reset leaves the memory deselected
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_q   <= 1'b0;
      we_q    <= 1'b0;
      gate_q  <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      sel_q   <= sel_d;
      we_q    <= we_d;
      gate_q  <= gate_d;
      drive_q <= drive_d;
    end
  end

  // Address and write data, held from take until next take
  // Held through hold and gap so the write end sees no change
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_q  <= {ADDR_W{1'b0}};
      wdata_q <= {DATA_W{1'b0}};
    end
    else if (take)
    begin
      addr_q  <= i_req_addr;
      wdata_q <= i_req_wdata;
    end
  end

  // Read capture at the end of the access
  // Sampled at least a full cycle after the slowest access time
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= {DATA_W{1'b0}};
      rsp_q   <= 1'b0;
    end
    else
    begin
      rsp_q <= read_end;
      if (read_end)
        rdata_q <= i_data_pins;
    end
  end

  // ==========================================================
  // Pin drive; selects rise after the strobe, and with it only when a reset cuts the pulse
  assign o_addr_pins            = addr_q;
  assign o_first_chip_select_n  = ~sel_q;
  assign o_second_chip_select_n = ~sel_q;
  assign o_write_strobe_n       = ~we_q;
  assign o_output_gate_n        = ~gate_q;
  assign o_data_pins            = wdata_q;
  assign o_data_pins_oe         = drive_q;
  assign o_rsp_valid            = rsp_q;
  assign o_rsp_rdata            = rdata_q;
endmodule
`default_nettype wire

// >>> testbench/sram_host_monitor.sv
`default_nettype none
module sram_host_monitor
  import sram_host_pkg::*;
(
  // Clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  // Request side
  input wire logic              i_req_valid,
  input wire logic              i_req_write,
  input wire logic              o_req_ready,
  input wire logic              o_rsp_valid,
  // Memory pins
  input wire logic [ADDR_W-1:0] o_addr_pins,
  input wire logic              o_first_chip_select_n,
  input wire logic              o_second_chip_select_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_output_gate_n,
  input wire logic [DATA_W-1:0] o_data_pins,
  input wire logic              o_data_pins_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Pin protocol
  default clocking ck @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire sel = !o_first_chip_select_n;

  AST_RD_STROBE: assert property (!o_output_gate_n |-> o_write_strobe_n && sel)
    else $error("strobe low in read");
  AST_ADDR_HELD: assert property (sel && $past(sel) |-> $stable(o_addr_pins))
    else $error("address moved while selected");
  AST_DATA_HELD: assert property (!$past(o_write_strobe_n) |->
    $stable(o_data_pins) && o_data_pins_oe) else $error("write data moved");
  AST_PULSE_LEN: assert property ($fell(o_write_strobe_n) |=>
    !o_write_strobe_n [*8] ##1 o_write_strobe_n) else $error("pulse length");
  AST_END_ORDER: assert property ($rose(o_write_strobe_n) |-> sel ##1 !sel)
    else $error("select rose with strobe");
  AST_SEL_PAIR: assert property (sel == !o_second_chip_select_n)
    else $error("selects differ");
  AST_RD_LAT: assert property (i_req_valid && o_req_ready && !i_req_write
    |-> ##14 o_rsp_valid) else $error("read answer late");
  AST_GATE_WR: assert property (!o_write_strobe_n |-> o_output_gate_n && sel)
    else $error("gate low in write");
  AST_DESEL_FLOAT: assert property (o_first_chip_select_n |->
    !o_data_pins_oe && o_write_strobe_n && o_output_gate_n)
    else $error("deselected pins active");

  cover property ($rose(o_rsp_valid));
  cover property ($fell(o_write_strobe_n));
  cover property (i_req_valid && !o_req_ready);
endmodule
bind sram_host_ctrl sram_host_monitor i_mon (
  .i_clk                  (i_clk),
  .i_rst_n                (i_rst_n),
  .i_req_valid            (i_req_valid),
  .i_req_write            (i_req_write),
  .o_req_ready            (o_req_ready),
  .o_rsp_valid            (o_rsp_valid),
  .o_addr_pins            (o_addr_pins),
  .o_first_chip_select_n  (o_first_chip_select_n),
  .o_second_chip_select_n (o_second_chip_select_n),
  .o_write_strobe_n       (o_write_strobe_n),
  .o_output_gate_n        (o_output_gate_n),
  .o_data_pins            (o_data_pins),
  .o_data_pins_oe         (o_data_pins_oe)
);
`default_nettype wire

// >>> testbench/sram_dev_model.sv
`default_nettype none
module sram_dev_model
  import sram_host_pkg::*;
#(
  parameter int ACC_NS = 12
)
(
  // Pins from host
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              i_sel1_n,
  input wire logic              i_sel2_n,
  input wire logic              i_strobe_n,
  input wire logic              i_gate_n,
  input wire logic [DATA_W-1:0] i_host_data,
  input wire logic              i_host_oe,
  // Resolved data wire
  output logic [DATA_W-1:0]     o_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Array and pin logic
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] junk = 4'h5;
  logic [DATA_W-1:0] rd_val;
  logic              armed = 1'b0;
  wire wr_off = i_sel1_n | i_sel2_n | i_strobe_n;
  wire rd_on  = !i_sel1_n & !i_sel2_n & i_strobe_n & !i_gate_n;
  // Floating pins churn so stale data never looks valid
  always #3 junk = junk + 4'h7;
  // Write begins on the overlap and lands when it ends
  always @(negedge wr_off) armed = 1'b1;
  always @(posedge wr_off)
    if (armed)
    begin
      mem[i_addr] = i_host_oe ? i_host_data : junk;
      armed = 1'b0;
    end
  // Read path with access delay
  assign #(ACC_NS) rd_val = mem[i_addr];
  assign o_wire = i_host_oe ? i_host_data
                : rd_on ? rd_val : junk;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_host_pkg::*;
  // ==========================================
  // Design and device
  logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0;
  logic [ADDR_W-1:0] i_req_addr = '0, o_addr_pins;
  logic [DATA_W-1:0] i_req_wdata = '0, o_rsp_rdata, i_data_pins, o_data_pins;
  logic o_req_ready, o_rsp_valid, o_data_pins_oe, o_output_gate_n;
  logic o_first_chip_select_n, o_second_chip_select_n, o_write_strobe_n;
  int   fail_count = 0, total_checks = 0;
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] shadow [int];
  int   written [$];
  logic [ADDR_W-1:0] ca [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h0001};

  sram_host_ctrl i_sram_host_ctrl (
    .i_clk                  (i_clk),
    .i_rst_n                (i_rst_n),
    .i_req_valid            (i_req_valid),
    .i_req_write            (i_req_write),
    .i_req_addr             (i_req_addr),
    .i_req_wdata            (i_req_wdata),
    .o_req_ready            (o_req_ready),
    .o_rsp_valid            (o_rsp_valid),
    .o_rsp_rdata            (o_rsp_rdata),
    .o_addr_pins            (o_addr_pins),
    .o_first_chip_select_n  (o_first_chip_select_n),
    .o_second_chip_select_n (o_second_chip_select_n),
    .o_write_strobe_n       (o_write_strobe_n),
    .o_output_gate_n        (o_output_gate_n),
    .i_data_pins            (i_data_pins),
    .o_data_pins            (o_data_pins),
    .o_data_pins_oe         (o_data_pins_oe)
  );
  sram_dev_model #(.ACC_NS(T_AA_NS)) i_sram_dev_model (.i_addr(o_addr_pins),
    .i_sel1_n(o_first_chip_select_n), .i_sel2_n(o_second_chip_select_n),
    .i_strobe_n(o_write_strobe_n), .i_gate_n(o_output_gate_n),
    .i_host_data(o_data_pins), .i_host_oe(o_data_pins_oe),
    .o_wire(i_data_pins));

  // Clock
  initial forever #2 i_clk = ~i_clk;

  task automatic check(string what, logic [DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One request, held until taken
  task automatic access(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(negedge i_clk);
    i_req_write = wr;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1)
      @(negedge i_clk);
    if (wr)
    begin
      shadow[a] = d;
      written.push_back(a);
    end
    else
      exp_q.push_back(shadow[a]);
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Answer watcher
  always @(negedge i_clk)
    if (o_rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("rsp_unexpected", 4'h1, 4'h0);
      else
        check("rdata", o_rsp_rdata, exp_q.pop_front());
    end

  // Watchdog
  initial
  begin
    #40000;
    fail_count++;
    give_verdict();
  end

  // Tests
  initial
  begin
    void'($urandom(32'hd4b1));
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
      access(1'b1, ca[i], 4'hf ^ 4'(i * 5));
    for (int i = 0; i < 4; i++)
      access(1'b0, ca[i], 4'h0);
    access(1'b1, 16'hffff, 4'h3);
    access(1'b0, 16'hffff, 4'h0);
    $display("test corners done");
    repeat (40)
      if (($urandom % 2) == 0)
        access(1'b1, 16'($urandom), 4'($urandom));
      else
        access(1'b0, 16'(written[$urandom % written.size()]), 4'h0);
    $display("test random done");
    access(1'b1, 16'h1234, 4'h9);
    void'(written.pop_back());
    shadow.delete(16'h1234);
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    check("standby", {o_first_chip_select_n, o_second_chip_select_n,
      o_write_strobe_n, o_data_pins_oe}, 4'he);
    i_rst_n = 1'b1;
    access(1'b0, ca[2], 4'h0);
    repeat (30) @(negedge i_clk);
    check("pending", 4'(exp_q.size()), 4'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
